/* File: bcdau_top.sv */
// Purpose: Four-digit BCD compare, add, subtract and multiply unit with status coils.
// Assumes: One AHB-Lite master, zero-wait slave while the clock enable is high.
// Notes: The whole operation completes in the data phase of the control write.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module bcdau_top
    import bcdau_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [BCDAU_ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o,
    output bcdau_coils_t coils_o,
    output logic [15:0] acc_o,
    output logic [15:0] aux_o
);

    logic dp_valid_reg;
    logic dp_write_reg;
    logic [BCDAU_ADDR_W-1:0] dp_addr_reg;
    logic wr_en;
    logic rd_en;
    logic [3:0] ctrl_reg;
    logic [15:0] const_reg;
    logic [7:0] ref_lo_reg;
    logic [7:0] ref_hi_reg;
    logic [15:0] acc_reg;
    logic [15:0] aux_reg;
    bcdau_coils_t coils_reg;
    bcdau_irq_t irq_stat_reg;
    bcdau_irq_t irq_en_reg;
    bcdau_op_t op_in;
    logic src_const;
    logic power;
    logic exec_req;
    logic exec_go;
    logic [15:0] opnd_bcd;
    logic [13:0] acc_val;
    logic [13:0] opnd_val;
    logic [14:0] sum;
    logic [14:0] diff;
    logic [27:0] prod;
    logic [31:0] prod_bcd;
    logic [31:0] res_bcd;
    logic [15:0] acc_next;
    logic [15:0] aux_next;
    bcdau_coils_t coils_next;
    bcdau_irq_t irq_ev;

    // Address phase is registered; hsize is ignored since only whole words are mapped.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else if (ce_i && hready_i) begin
            dp_valid_reg <= hsel_i && htrans_i[1];
            dp_write_reg <= hwrite_i;
            dp_addr_reg <= haddr_i;
        end
    end

    // Stalling the bus while frozen keeps a data phase from being lost.
    assign hreadyout_o = ce_i;
    assign hresp_o = 1'b0;
    assign wr_en = dp_valid_reg && dp_write_reg && ce_i;
    assign rd_en = dp_valid_reg && !dp_write_reg;

    assign op_in = bcdau_op_t'(hwdata_i[BCDAU_CTRL_OP_LSB +: 2]);
    assign src_const = hwdata_i[BCDAU_CTRL_SRC_BIT];
    assign power = hwdata_i[BCDAU_CTRL_POWER_BIT];
    assign exec_req = wr_en && (dp_addr_reg == BCDAU_CTRL_OFS);
    assign exec_go = exec_req && power; // RL1

    assign opnd_bcd = src_const ? const_reg : {ref_hi_reg, ref_lo_reg}; // RL2 RL17
    assign acc_val = bcdau_bcd_to_bin(acc_reg);
    assign opnd_val = bcdau_bcd_to_bin(opnd_bcd);

    always_comb begin
        sum = 15'(acc_val) + 15'(opnd_val);
        diff = 15'h0000;
        prod = 28'(acc_val) * 28'(opnd_val); // RL13
        prod_bcd = bcdau_bin_to_bcd8(prod[26:0]);
        res_bcd = 32'h0000_0000;
        acc_next = acc_reg;
        aux_next = aux_reg;
        coils_next = coils_reg;
        unique case (op_in)
            BCDAU_OP_CMP: begin
                coils_next.gt = acc_val > opnd_val; // RL3 RL18
                coils_next.eq = acc_val == opnd_val; // RL4 RL18
                coils_next.lt = acc_val < opnd_val; // RL5 RL18
            end
            BCDAU_OP_ADD: begin
                coils_next.carry = sum > BCDAU_MAX4; // RL7 RL18
                diff = coils_next.carry ? sum - BCDAU_MOD4 : sum;
                res_bcd = bcdau_bin_to_bcd8(27'(diff));
                acc_next = res_bcd[15:0]; // RL6
                coils_next.zero = acc_next == 16'h0000; // RL8 RL9 RL18
            end
            BCDAU_OP_SUB: begin
                coils_next.carry = acc_val < opnd_val; // RL11 RL18
                // The borrow case wraps to the ten's complement of the magnitude.
                diff = coils_next.carry ? sum - 15'(opnd_val) - 15'(opnd_val) + BCDAU_MOD4
                                        : 15'(acc_val) - 15'(opnd_val); // RL10 RL11
                res_bcd = bcdau_bin_to_bcd8(27'(diff));
                acc_next = res_bcd[15:0];
                coils_next.zero = !coils_next.carry && (diff == 15'h0000); // RL12 RL18
            end
            BCDAU_OP_MUL: begin
                acc_next = prod_bcd[15:0]; // RL14
                aux_next = prod_bcd[31:16]; // RL15
                coils_next.zero = prod == 28'h000_0000; // RL16 RL18
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= BCDAU_CTRL_RST;
            const_reg <= BCDAU_OPND_RST;
            ref_lo_reg <= BCDAU_OPND_RST[7:0];
            ref_hi_reg <= BCDAU_OPND_RST[15:8];
        end else if (wr_en) begin
            if (dp_addr_reg == BCDAU_CTRL_OFS) begin
                ctrl_reg <= hwdata_i[3:0];
            end
            if (dp_addr_reg == BCDAU_CONST_OFS) begin
                const_reg <= hwdata_i[15:0];
            end
            if (dp_addr_reg == BCDAU_REF_LO_OFS) begin
                ref_lo_reg <= hwdata_i[7:0];
            end
            if (dp_addr_reg == BCDAU_REF_HI_OFS) begin
                ref_hi_reg <= hwdata_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_reg <= BCDAU_ACC_RST;
            aux_reg <= BCDAU_AUX_RST;
            coils_reg <= '0;
        end else if (exec_go) begin
            acc_reg <= acc_next; // RL1
            aux_reg <= aux_next;
            coils_reg <= coils_next;
        end else if (wr_en && (dp_addr_reg == BCDAU_ACC_OFS)) begin
            acc_reg <= hwdata_i[15:0];
        end
    end

    assign irq_ev.done_ev = exec_go;
    assign irq_ev.carry_ev = exec_go && coils_next.carry && (op_in inside {BCDAU_OP_ADD, BCDAU_OP_SUB});
    assign irq_ev.zero_ev = exec_go && coils_next.zero && (op_in != BCDAU_OP_CMP);

    // A new event wins over a clear in the same cycle so that nothing is lost.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_reg <= BCDAU_IRQ_RST;
            irq_en_reg <= BCDAU_IRQ_RST;
        end else if (ce_i) begin
            if (wr_en && (dp_addr_reg == BCDAU_IRQ_CLR_OFS)) begin
                irq_stat_reg <= (irq_stat_reg & ~hwdata_i[2:0]) | irq_ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_ev;
            end
            if (wr_en && (dp_addr_reg == BCDAU_IRQ_EN_OFS)) begin
                irq_en_reg <= hwdata_i[2:0];
            end
        end
    end

    assign irq_o = |(irq_stat_reg & irq_en_reg);
    assign coils_o = coils_reg;
    assign acc_o = acc_reg;
    assign aux_o = aux_reg;

    always_comb begin
        hrdata_o = 32'h0000_0000;
        if (rd_en) begin
            unique case (dp_addr_reg)
                BCDAU_CTRL_OFS: hrdata_o = 32'(ctrl_reg);
                BCDAU_CONST_OFS: hrdata_o = 32'(const_reg);
                BCDAU_REF_LO_OFS: hrdata_o = 32'(ref_lo_reg);
                BCDAU_REF_HI_OFS: hrdata_o = 32'(ref_hi_reg);
                BCDAU_ACC_OFS: hrdata_o = 32'(acc_reg);
                BCDAU_AUX_OFS: hrdata_o = 32'(aux_reg);
                BCDAU_COILS_OFS: hrdata_o = 32'(coils_reg);
                BCDAU_IRQ_STAT_OFS: hrdata_o = 32'(irq_stat_reg);
                BCDAU_IRQ_EN_OFS: hrdata_o = 32'(irq_en_reg);
                default: hrdata_o = 32'h0000_0000;
            endcase
        end
    end

    default clocking cb_main @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_no_power;
        exec_req && !power |=> $stable(acc_reg) && $stable(aux_reg) && $stable(coils_reg);
    endproperty
    a_no_power: assert property (p_no_power) else $error("Instruction ran without power flow."); // RL1

    property p_cmp_gt;
        exec_go && (op_in == BCDAU_OP_CMP) && (acc_val > opnd_val) |=> coils_reg.gt && !coils_reg.eq && !coils_reg.lt;
    endproperty
    a_cmp_gt: assert property (p_cmp_gt) else $error("Greater coil wrong after compare."); // RL3

    property p_cmp_eq;
        exec_go && (op_in == BCDAU_OP_CMP) && (acc_val == opnd_val) |=> coils_reg.eq && !coils_reg.gt && !coils_reg.lt;
    endproperty
    a_cmp_eq: assert property (p_cmp_eq) else $error("Equal coil wrong after compare."); // RL4

    property p_cmp_lt;
        exec_go && (op_in == BCDAU_OP_CMP) && (acc_val < opnd_val) |=> coils_reg.lt && !coils_reg.gt && !coils_reg.eq;
    endproperty
    a_cmp_lt: assert property (p_cmp_lt) else $error("Less coil wrong after compare."); // RL5

    property p_cmp_keeps;
        exec_go && (op_in == BCDAU_OP_CMP) |=> $stable(acc_reg) && $stable(coils_reg.carry) && $stable(coils_reg.zero);
    endproperty
    a_cmp_keeps: assert property (p_cmp_keeps) else $error("Compare disturbed accumulator or flags."); // RL18

    property p_ref_pair;
        exec_go && (op_in == BCDAU_OP_CMP) && !src_const && (acc_reg == {ref_hi_reg, ref_lo_reg}) |=> coils_reg.eq;
    endproperty
    a_ref_pair: assert property (p_ref_pair) else $error("Group operand assembled wrongly."); // RL17

    property p_add_sum;
        exec_go && (op_in == BCDAU_OP_ADD) |=>
            (32'(bcdau_bcd_to_bin(acc_reg)) + (coils_reg.carry ? 32'(BCDAU_MOD4) : 32'h0)
             == 32'($past(acc_val)) + 32'($past(opnd_val)));
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("Add result or carry wrong."); // RL7

    property p_add_wrap;
        exec_go && (op_in == BCDAU_OP_ADD) && (sum == BCDAU_MOD4) |=> coils_reg.carry && coils_reg.zero && (acc_reg == 16'h0000);
    endproperty
    a_add_wrap: assert property (p_add_wrap) else $error("Overflow to zero flags wrong."); // RL9

    property p_sub_borrow;
        exec_go && (op_in == BCDAU_OP_SUB) && (acc_val < opnd_val) |=> coils_reg.carry && !coils_reg.zero &&
            (32'(bcdau_bcd_to_bin(acc_reg)) + 32'($past(opnd_val)) == 32'($past(acc_val)) + 32'(BCDAU_MOD4));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("Borrow result wrong."); // RL11

    property p_sub_zero;
        exec_go && (op_in == BCDAU_OP_SUB) && (acc_val == opnd_val) |=> coils_reg.zero && !coils_reg.carry;
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("Zero difference not flagged."); // RL12

    property p_mul_split;
        exec_go && (op_in == BCDAU_OP_MUL) |=>
            (32'(bcdau_bcd_to_bin(aux_reg)) * 32'(BCDAU_MOD4) + 32'(bcdau_bcd_to_bin(acc_reg))
             == 32'($past(acc_val)) * 32'($past(opnd_val)));
    endproperty
    a_mul_split: assert property (p_mul_split) else $error("Product digits misplaced."); // RL15

    property p_mul_zero;
        exec_go && (op_in == BCDAU_OP_MUL) |=> (coils_reg.zero == ((acc_reg == 16'h0000) && (aux_reg == 16'h0000)));
    endproperty
    a_mul_zero: assert property (p_mul_zero) else $error("Zero product flag wrong."); // RL16

    property p_irq_level;
        exec_go && irq_en_reg.done_ev |=> irq_o ##1 (irq_o || $past(wr_en));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt did not hold after execution.");

    // Expectations below are rebuilt in binary from the sampled operands, so a conversion slip shows up.
    // The bus-side properties cover the clock enable and the sticky status, which the tests reach rarely.

    property p_add_carry;
        exec_go && (op_in == BCDAU_OP_ADD) |=> coils_reg.carry == ($past(sum) > BCDAU_MAX4);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("Carry coil wrong after add."); // RL7

    property p_add_zero;
        exec_go && (op_in == BCDAU_OP_ADD) |=>
            coils_reg.zero == (($past(sum) == 15'h0000) || ($past(sum) == BCDAU_MOD4));
    endproperty
    a_add_zero: assert property (p_add_zero) else $error("Zero coil wrong after add."); // RL8

    property p_bcd_result;
        exec_go && (op_in != BCDAU_OP_CMP) |=> (acc_reg[15:12] <= 4'h9) && (acc_reg[11:8] <= 4'h9) &&
            (acc_reg[7:4] <= 4'h9) && (acc_reg[3:0] <= 4'h9);
    endproperty
    a_bcd_result: assert property (p_bcd_result) else $error("Accumulator holds a digit above nine."); // RL6

    property p_sub_plain;
        exec_go && (op_in == BCDAU_OP_SUB) && (acc_val >= opnd_val) |=> !coils_reg.carry &&
            (32'(bcdau_bcd_to_bin(acc_reg)) + 32'($past(opnd_val)) == 32'($past(acc_val)));
    endproperty
    a_sub_plain: assert property (p_sub_plain) else $error("Plain difference wrong."); // RL10

    property p_mul_low;
        exec_go && (op_in == BCDAU_OP_MUL) |=>
            (32'(bcdau_bcd_to_bin(acc_reg)) == (32'($past(acc_val)) * 32'($past(opnd_val))) % 32'(BCDAU_MOD4));
    endproperty
    a_mul_low: assert property (p_mul_low) else $error("Low product digits wrong."); // RL14

    property p_mul_keeps;
        exec_go && (op_in == BCDAU_OP_MUL) |=> $stable(coils_reg.carry) && $stable(coils_reg.gt) &&
            $stable(coils_reg.eq) && $stable(coils_reg.lt);
    endproperty
    a_mul_keeps: assert property (p_mul_keeps) else $error("Multiply disturbed foreign coils."); // RL18

    property p_arith_keeps;
        exec_go && (op_in inside {BCDAU_OP_ADD, BCDAU_OP_SUB}) |=> $stable(aux_reg) &&
            $stable(coils_reg.gt) && $stable(coils_reg.eq) && $stable(coils_reg.lt);
    endproperty
    a_arith_keeps: assert property (p_arith_keeps) else $error("Add or subtract disturbed foreign state."); // RL18

    property p_irq_sticky;
        !(wr_en && (dp_addr_reg == BCDAU_IRQ_CLR_OFS)) |=>
            ((irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg));
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("Status bit dropped without a clear.");

    // Freezing is checked here because a stalled bus would otherwise hide a lost update.
    property p_frozen;
        !ce_i |=> $stable(acc_reg) && $stable(aux_reg) && $stable(coils_reg) && $stable(ctrl_reg) &&
            $stable(irq_stat_reg) && $stable(irq_en_reg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("State changed while the clock enable was low.");

    c_cmp_gt: cover property (exec_go && (op_in == BCDAU_OP_CMP) && (acc_val > opnd_val));
    c_add_wrap: cover property (exec_go && (op_in == BCDAU_OP_ADD) && (sum == BCDAU_MOD4));
    c_sub_borrow: cover property (exec_go && (op_in == BCDAU_OP_SUB) && (acc_val < opnd_val));
    c_mul_big: cover property (exec_go && (op_in == BCDAU_OP_MUL) && (prod > 28'(BCDAU_MAX4)));
    c_group_eq: cover property (exec_go && (op_in == BCDAU_OP_CMP) && !src_const && (acc_val == opnd_val));

endmodule : bcdau_top

/* File: bcdau_pkg.sv */
// Purpose: Constants, types and conversion functions of the BCD arithmetic and compare unit.
// Assumes: AHB-Lite register access, one 20 MHz clock, 32-bit data words.
// Notes: Operands and results are four-digit BCD words; a nibble above nine is taken as nine.
// Behaviour
// RL1 - Execute only when rung power flows.
// RL2 - Operand is two groups or BCD constant.
// RL3 - Compare sets greater coil 772.
// RL4 - Compare sets equal coil 773.
// RL5 - Compare sets less coil 774.
// RL6 - Add stores four-digit BCD sum.
// RL7 - Sum above 9999 sets carry 775.
// RL8 - All-zero add result sets zero 776.
// RL9 - Overflow to zero sets carry and zero.
// RL10 - Non-negative difference stored unchanged.
// RL11 - Negative difference: borrow, store 10000 minus magnitude.
// RL12 - Zero difference sets zero 776.
// RL13 - Multiply forms up to eight-digit product.
// RL14 - Low four product digits to accumulator.
// RL15 - Product digits five-eight to auxiliary.
// RL16 - Zero product sets zero 776.
// RL17 - Higher group gives the upper digits.
// RL18 - Unmet own coils clear on execution.
package bcdau_pkg;

    localparam int unsigned BCDAU_ADDR_W = 8;
    localparam logic [7:0] BCDAU_CTRL_OFS = 8'h00;
    localparam logic [7:0] BCDAU_CONST_OFS = 8'h04;
    localparam logic [7:0] BCDAU_REF_LO_OFS = 8'h08;
    localparam logic [7:0] BCDAU_REF_HI_OFS = 8'h0c;
    localparam logic [7:0] BCDAU_ACC_OFS = 8'h10;
    localparam logic [7:0] BCDAU_AUX_OFS = 8'h14;
    localparam logic [7:0] BCDAU_COILS_OFS = 8'h18;
    localparam logic [7:0] BCDAU_IRQ_STAT_OFS = 8'h1c;
    localparam logic [7:0] BCDAU_IRQ_CLR_OFS = 8'h20;
    localparam logic [7:0] BCDAU_IRQ_EN_OFS = 8'h24;

    localparam int unsigned BCDAU_CTRL_OP_LSB = 0;
    localparam int unsigned BCDAU_CTRL_SRC_BIT = 2;
    localparam int unsigned BCDAU_CTRL_POWER_BIT = 3;

    localparam logic [3:0] BCDAU_CTRL_RST = 4'h0;
    localparam logic [15:0] BCDAU_ACC_RST = 16'h0000;
    localparam logic [15:0] BCDAU_AUX_RST = 16'h0000;
    localparam logic [15:0] BCDAU_OPND_RST = 16'h0000;
    localparam logic [2:0] BCDAU_IRQ_RST = 3'h0;

    localparam logic [14:0] BCDAU_MAX4 = 15'h270f;
    localparam logic [14:0] BCDAU_MOD4 = 15'h2710;

    localparam logic [9:0] BCDAU_COIL_GT_IDX = 10'h304;
    localparam logic [9:0] BCDAU_COIL_ZERO_IDX = 10'h308;

    typedef enum logic [1:0] {
        BCDAU_OP_CMP,
        BCDAU_OP_ADD,
        BCDAU_OP_SUB,
        BCDAU_OP_MUL
    } bcdau_op_t;

    typedef struct packed {
        logic zero;
        logic carry;
        logic lt;
        logic eq;
        logic gt;
    } bcdau_coils_t;

    typedef struct packed {
        logic zero_ev;
        logic carry_ev;
        logic done_ev;
    } bcdau_irq_t;

    function automatic logic [13:0] bcdau_bcd_to_bin(input logic [15:0] b);
        logic [13:0] r;
        logic [3:0] d;
        r = 14'h0000;
        for (int i = 3; i >= 0; i--) begin
            d = (b[i*4 +: 4] > 4'h9) ? 4'h9 : b[i*4 +: 4];
            r = 14'(r * 14'h000a + 14'(d));
        end
        return r;
    endfunction : bcdau_bcd_to_bin

    function automatic logic [31:0] bcdau_bin_to_bcd8(input logic [26:0] v);
        logic [31:0] b;
        b = 32'h0000_0000;
        for (int i = 26; i >= 0; i--) begin
            for (int d = 0; d < 8; d++) begin
                if (b[d*4 +: 4] > 4'h4) begin
                    b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
                end
            end
            b = {b[30:0], v[i]};
        end
        return b;
    endfunction : bcdau_bin_to_bcd8

endpackage : bcdau_pkg

/* File: tb_bcdau_top.sv */
// Purpose: Self-checking bench of the BCD compare, add, subtract and multiply unit.
// Assumes: Zero-wait AHB-Lite slave, hready fed back from hreadyout, 50 ns clock.
// Notes: Expected results are worked out by hand as BCD words in the scenario tables.
`timescale 1ns/1ps

module tb_bcdau_top;
    import bcdau_pkg::*;
    logic clk_i, rst_n_i, ce_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
    logic [7:0] haddr_i;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i, hrdata_o;
    logic [15:0] acc_o, aux_o;
    bcdau_coils_t coils_o;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_cyc = 0;

    bcdau_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .irq_o(irq_o), .coils_o(coils_o), .acc_o(acc_o), .aux_o(aux_o));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // A hung bus never returns, so the cycle ceiling ends the run instead.
    always @(posedge clk_i) begin
        n_cyc++;
        if (n_cyc == 4000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wait_rdy;
        do begin
            @(posedge clk_i);
        end while (hreadyout_o !== 1'b1);
    endtask : wait_rdy

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        haddr_i <= a;
        htrans_i <= 2'b10;
        hwrite_i <= w;
        wait_rdy();
        htrans_i <= 2'b00;
        hwdata_i <= d;
        wait_rdy();
        q = hrdata_o;
        #1;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk({31'h0, hresp_o}, 32'h0, "okay response");
        chk(q, e, msg);
    endtask : rd

    task automatic ex(input bcdau_op_t op, input logic src);
        wr(BCDAU_CTRL_OFS, {28'h0, 1'b1, src, op});
    endtask : ex

    task automatic op_chk(input bcdau_op_t op, input logic [15:0] a, k, r, input logic [1:0] f);
        wr(BCDAU_ACC_OFS, {16'h0, a});
        wr(BCDAU_CONST_OFS, {16'h0, k});
        ex(op, 1'b1);
        chk({16'h0, acc_o}, {16'h0, r}, "accumulator");
        // Multiply leaves carry alone, so only its zero coil is judged.
        chk({30'h0, (op == BCDAU_OP_MUL) ? 1'b0 : coils_o.carry, coils_o.zero}, {30'h0, f}, "carry zero");
    endtask : op_chk

    task automatic do_reset;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
    endtask : do_reset

    task automatic t_reset;
        chk({16'h0, acc_o}, 32'h0, "acc reset");
        chk({16'h0, aux_o}, 32'h0, "aux reset");
        chk({27'h0, coils_o}, 32'h0, "coils reset");
        chk({31'h0, irq_o}, 32'h0, "irq reset");
        rd(BCDAU_CTRL_OFS, 32'h0, "ctrl reset");
        wr(8'h3c, 32'h1234_5678);
        rd(8'h3c, 32'h0, "unmapped");
        wr(BCDAU_AUX_OFS, 32'h1111);
        rd(BCDAU_AUX_OFS, 32'h0, "aux read only");
    endtask : t_reset

    task automatic t_power;
        wr(BCDAU_ACC_OFS, 32'h0005);
        wr(BCDAU_CONST_OFS, 32'h0003);
        wr(BCDAU_CTRL_OFS, 32'h0000_0005);
        chk({16'h0, acc_o}, 32'h0005, "no power");
        rd(BCDAU_CTRL_OFS, 32'h5, "ctrl readback");
        ex(BCDAU_OP_ADD, 1'b1);
        chk({16'h0, acc_o}, 32'h0008, "power");
    endtask : t_power

    task automatic t_cmp;
        logic [15:0] kv [3] = '{16'h1234, 16'h1235, 16'h0999};
        logic [2:0] ev [3] = '{3'b010, 3'b100, 3'b001};
        wr(BCDAU_ACC_OFS, 32'h1234);
        for (int i = 0; i < 3; i++) begin
            wr(BCDAU_CONST_OFS, {16'h0, kv[i]});
            ex(BCDAU_OP_CMP, 1'b1);
            chk({29'h0, coils_o.lt, coils_o.eq, coils_o.gt}, {29'h0, ev[i]}, "compare");
        end
        // Swapped groups would read 3312 and turn the answer into less-than.
        wr(BCDAU_REF_LO_OFS, 32'h33);
        wr(BCDAU_REF_HI_OFS, 32'h12);
        ex(BCDAU_OP_CMP, 1'b0);
        chk({29'h0, coils_o.lt, coils_o.eq, coils_o.gt}, 32'h1, "group compare");
        chk({16'h0, acc_o}, 32'h1234, "compare keeps acc");
        rd(BCDAU_COILS_OFS, 32'h1, "coil register");
        wr(BCDAU_REF_LO_OFS, 32'h34);
        ex(BCDAU_OP_CMP, 1'b0);
        chk({29'h0, coils_o.lt, coils_o.eq, coils_o.gt}, 32'h2, "group equal");
    endtask : t_cmp

    task automatic t_add;
        op_chk(BCDAU_OP_ADD, 16'h9999, 16'h0001, 16'h0000, 2'b11);
        op_chk(BCDAU_OP_ADD, 16'h4567, 16'h1234, 16'h5801, 2'b00);
        op_chk(BCDAU_OP_ADD, 16'h5000, 16'h5001, 16'h0001, 2'b10);
        op_chk(BCDAU_OP_ADD, 16'h0000, 16'h0000, 16'h0000, 2'b01);
    endtask : t_add

    task automatic t_sub;
        op_chk(BCDAU_OP_SUB, 16'h0100, 16'h0250, 16'h9850, 2'b10);
        op_chk(BCDAU_OP_SUB, 16'h0250, 16'h0250, 16'h0000, 2'b01);
        op_chk(BCDAU_OP_SUB, 16'h0300, 16'h0100, 16'h0200, 2'b00);
        op_chk(BCDAU_OP_SUB, 16'h0000, 16'h9999, 16'h0001, 2'b10);
    endtask : t_sub

    task automatic t_mul;
        op_chk(BCDAU_OP_MUL, 16'h9999, 16'h9999, 16'h0001, 2'b00);
        chk({16'h0, aux_o}, 32'h9998, "aux max");
        op_chk(BCDAU_OP_MUL, 16'h0000, 16'h1234, 16'h0000, 2'b01);
        chk({16'h0, aux_o}, 32'h0000, "aux zero");
        op_chk(BCDAU_OP_MUL, 16'h1234, 16'h5678, 16'h6652, 2'b00);
        chk({16'h0, aux_o}, 32'h0700, "aux upper");
        rd(BCDAU_AUX_OFS, 32'h0700, "aux register");
    endtask : t_mul

    task automatic t_irq;
        wr(BCDAU_IRQ_CLR_OFS, 32'h7);
        rd(BCDAU_IRQ_STAT_OFS, 32'h0, "status cleared");
        wr(BCDAU_IRQ_EN_OFS, 32'h1);
        ex(BCDAU_OP_CMP, 1'b1);
        chk({31'h0, irq_o}, 32'h1, "irq raised");
        wr(BCDAU_IRQ_EN_OFS, 32'h0);
        chk({31'h0, irq_o}, 32'h0, "irq masked");
        rd(BCDAU_IRQ_STAT_OFS, 32'h1, "status sticky");
        wr(BCDAU_IRQ_CLR_OFS, 32'h1);
        rd(BCDAU_IRQ_STAT_OFS, 32'h0, "done cleared");
        wr(BCDAU_IRQ_EN_OFS, 32'h2);
        op_chk(BCDAU_OP_ADD, 16'h9999, 16'h0001, 16'h0000, 2'b11);
        chk({31'h0, irq_o}, 32'h1, "carry irq");
        rd(BCDAU_IRQ_STAT_OFS, 32'h7, "all events");
        rd(BCDAU_IRQ_EN_OFS, 32'h2, "enable readback");
        wr(BCDAU_IRQ_CLR_OFS, 32'h7);
        chk({31'h0, irq_o}, 32'h0, "irq cleared");
        rd(BCDAU_IRQ_CLR_OFS, 32'h0, "clear reads zero");
    endtask : t_irq

    // A write is launched while the enable drops, so it must wait and then land intact.
    task automatic t_ce;
        wr(BCDAU_ACC_OFS, 32'h0042);
        fork
            wr(BCDAU_ACC_OFS, 32'h4321);
            begin
                @(posedge clk_i);
                ce_i <= 1'b0;
                repeat (3) @(posedge clk_i);
                #1;
                chk({31'h0, hreadyout_o}, 32'h0, "stalled");
                chk({16'h0, acc_o}, 32'h0042, "frozen acc");
                @(posedge clk_i);
                ce_i <= 1'b1;
            end
        join
        chk({16'h0, acc_o}, 32'h4321, "write after stall");
        rd(BCDAU_ACC_OFS, 32'h4321, "acc after stall");
    endtask : t_ce

    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        hsel_i = 1'b1;
        haddr_i = 8'h00;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        do_reset();
        t_reset();
        t_power();
        t_cmp();
        t_add();
        t_sub();
        t_mul();
        t_irq();
        t_ce();
        do_reset();
        t_reset();
        finish_test();
    end
endmodule : tb_bcdau_top
